// *** sfs_pkg.sv ***
// shared constants and types of the serial flash status and read logic
package sfs_pkg;

    // instruction codes
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_VWREN = 8'h50;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_WRSR  = 8'h01;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_FAST  = 8'h0b;
    localparam logic [7:0] OP_DOUT  = 8'h3b;
    localparam logic [7:0] OP_QOUT  = 8'h6b;
    localparam logic [7:0] OP_DIO   = 8'hbb;

    // status word field positions and masks
    localparam int          ST_BUSY      = 0;
    localparam int          ST_WEL       = 1;
    localparam int          ST_QE        = 9;
    localparam logic [15:0] ST_WR_MASK   = 16'h7ffc;
    localparam logic [15:0] ST_LOCK_MASK = 16'h3c00;
    localparam logic [15:0] ST_PROTECT_MODE_HIGH_MASK = 16'h0100;
    localparam logic [15:0] ST_RESET     = 16'h0000;

    // frame lengths counted in serial clocks
    localparam logic [5:0] CMD_ONLY_CLKS  = 6'h08;
    localparam logic [5:0] WSR_SHORT_CLKS = 6'h10;
    localparam logic [5:0] WSR_LONG_CLKS  = 6'h18;
    localparam logic [5:0] NBITS_MAX      = 6'h3f;

    // last clock index of each fixed-length link phase
    localparam logic [4:0] CMD_LAST   = 5'h07;
    localparam logic [4:0] ADDR_LAST  = 5'h17;
    localparam logic [4:0] DADDR_LAST = 5'h0b;
    localparam logic [4:0] MODE_LAST  = 5'h03;
    localparam logic [4:0] DUMMY_LAST = 5'h07;

    // mode byte bits 5:4 that keep continuous read
    localparam logic [1:0] CONT_KEY = 2'h2;

    // timing
    localparam int CLK_PERIOD_NS   = 4;
    localparam int WSR_TIME_NS     = 15000000;
    localparam int WSR_CYCLES      =
        (WSR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // array behind the read instructions
    localparam int MEM_BYTES = 256;
    localparam int MEM_AW    = 8;

    typedef enum logic [2:0] {
        PH_CMD, PH_ADDR, PH_MODE, PH_DUMMY, PH_DATA, PH_STAT, PH_WSR, PH_IDLE
    } sfs_phase_t;

    typedef enum logic [1:0] {LN_ONE, LN_TWO, LN_FOUR} sfs_lanes_t;

    // link side state, clocked by the serial clock
    typedef struct packed {
        sfs_phase_t  phase;
        sfs_lanes_t  lanes;
        logic        dio;
        logic        cont;
        logic [4:0]  cnt;
        logic [5:0]  nbits;
        logic [7:0]  opcode;
        logic [23:0] addr;
        logic [7:0]  mode;
        logic [2:0]  pos;
        logic [15:0] shift;
    } sfs_link_t;

    // pin drive stage
    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] out;
    } sfs_pin_t;

    // core side state
    typedef struct packed {
        logic [MEM_BYTES-1:0][7:0] mem;
        logic [15:0]               nv;
        logic [15:0]               act;
        logic [15:0]               pend;
        logic [15:0]               view;
        logic                      write_latch;
        logic                      vwe;
        logic                      busy;
        logic                      cs_d;
    } sfs_core_t;

endpackage

// *** sfs_sync2.sv ***
// two flip-flop synchroniser for levels and quasi-static words
`timescale 1ns/1ps
`default_nettype none
module sfs_sync2 #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk,
    input  wire logic         clr,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge clr) begin
        if (clr) begin
            meta_q <= RST;
            q      <= RST;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** sfs_busy_timer.sv ***
// self-timed cycle counter, pulses done after a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module sfs_busy_timer #(
    parameter int CYCLES = 16
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic start,
    output var  logic done
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          run;
        logic          done;
    } sfs_tmr_t;

    sfs_tmr_t t_q;
    sfs_tmr_t t_d;

    // count down from start, one done pulse at the end
    always_comb begin
        t_d      = t_q;
        t_d.done = 1'b0;
        if (start) begin
            t_d.cnt = CW'(CYCLES - 1);
            t_d.run = 1'b1;
        end else if (t_q.run) begin
            if (t_q.cnt == '0) begin
                t_d.run  = 1'b0;
                t_d.done = 1'b1;
            end else begin
                t_d.cnt = t_q.cnt - CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign done = t_q.done;
endmodule
`default_nettype wire

// *** sfs_flash.sv ***
// serial flash status write and read instruction logic
//
// Functional notes
// - status write changes bits 7-2, 14-8 only
// - lock bits once set clear only by factory clear, or by reload when set volatile
// - non-volatile status write needs write latch set
// - volatile enable writes volatile copy, latch stays 0
// - volatile write cannot clear protect-high or locks
// - status write executes only at 8 or 16 bits
// - eight-bit write clears complement and quad, and protect-high on non-volatile write
// - non-volatile write runs timed busy cycle
// - write latch clears when the cycle ends
// - volatile write applies at once, busy stays 0
// - factory zero, non-volatile kept, volatile reloaded
// - read 03h then 24-bit address MSB first
// - command and address sampled on rising clock
// - data driven on falling edge, MSB first
// - address increments per byte until deselect
// - array reads ignored while busy, status reads still answered
// - fast, dual output and quad output reads take eight dummy clocks; dual I/O takes four mode clocks instead
// - dual output uses lines zero and one
// - quad output needs quad enable set
// - dual I/O address two bits per clock
// - mode bits 5:4 = 10 skip next instruction
// - other mode values need instruction again
// - line zero even bits, line one odd
// - dual data line one gets odd bits
`timescale 1ns/1ps
`default_nettype none
module sfs_flash
    import sfs_pkg::*;
#(
    parameter int WSR_CYC = WSR_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              factory_clr,
    input  wire logic              mem_wr_en,
    input  wire logic [MEM_AW-1:0] mem_wr_addr,
    input  wire logic [7:0]        mem_wr_data,
    input  wire logic              flash_sclk,
    input  wire logic              cs_n,
    input  wire logic [3:0]        io_in,
    output var  logic [3:0]        io_out,
    output var  logic [3:0]        io_oe,
    output var  logic [15:0]       status_word
);
    sfs_core_t   c_q;
    sfs_core_t   c_d;
    sfs_link_t   l_q;
    sfs_link_t   l_d;
    sfs_pin_t    p_q;
    sfs_pin_t    p_d;
    logic        fresh_q;
    logic        cs_s;
    logic        tmr_start;
    logic        tmr_done;
    logic [15:0] stat_s;
    logic [15:0] wrd;

    // merge written status into old word, keeping read-only and locks
    function automatic logic [15:0] wsr_merge(
        input logic [15:0] old,
        input logic [15:0] wv,
        input logic        vol
    );
        logic [15:0] r;
        r = (old & ~ST_WR_MASK) | (wv & ST_WR_MASK);
        r = r | (old & ST_LOCK_MASK);
        if (vol) begin
            r = r | (old & ST_PROTECT_MODE_HIGH_MASK);
        end
        return r;
    endfunction

    // last clock of a byte for a given lane count
    function automatic logic [2:0] byte_last(input sfs_lanes_t ln);
        logic [2:0] r;
        r = 3'h7;
        case (ln)
            LN_TWO:  r = 3'h3;
            LN_FOUR: r = 3'h1;
            default: r = 3'h7;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------ core

    // chip select into the core clock
    sfs_sync2 #(
        .W   (1),
        .RST (1'b1)
    ) u_cs_sync (
        .clk (core_clk),
        .clr (rst),
        .d   (cs_n),
        .q   (cs_s)
    );

    // self-timed non-volatile write cycle
    sfs_busy_timer #(
        .CYCLES (WSR_CYC)
    ) u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .start    (tmr_start),
        .done     (tmr_done)
    );

    // status byte order as shifted in: first byte is the low byte
    always_comb begin
        if (l_q.nbits == WSR_LONG_CLKS) begin
            wrd = {l_q.shift[7:0], l_q.shift[15:8]};
        end else begin
            wrd = {8'h00, l_q.shift[7:0]};
        end
    end

    // frame end handling; link state is still since the clock stops
    always_comb begin
        c_d       = c_q;
        tmr_start = 1'b0;
        c_d.cs_d  = cs_s;
        if (mem_wr_en) begin
            c_d.mem[mem_wr_addr] = mem_wr_data;
        end
        if (tmr_done) begin
            c_d.nv   = c_q.pend;
            c_d.act  = c_q.pend;
            c_d.busy = 1'b0;
            c_d.write_latch  = 1'b0;
        end
        if (cs_s && !c_q.cs_d && !c_q.busy) begin
            c_d.vwe = 1'b0;
            case (l_q.opcode)
                OP_WREN: begin
                    if (l_q.nbits == CMD_ONLY_CLKS) begin
                        c_d.write_latch = 1'b1;
                    end
                end
                OP_VWREN: begin
                    if (l_q.nbits == CMD_ONLY_CLKS) begin
                        c_d.vwe = 1'b1;
                    end
                end
                OP_WRDI: begin
                    if (l_q.nbits == CMD_ONLY_CLKS) begin
                        c_d.write_latch = 1'b0;
                    end
                end
                OP_WRSR: begin
                    if (l_q.nbits == WSR_SHORT_CLKS ||
                        l_q.nbits == WSR_LONG_CLKS) begin
                        if (c_q.write_latch) begin
                            c_d.pend  = wsr_merge(c_q.nv, wrd, 1'b0);
                            c_d.busy  = 1'b1;
                            tmr_start = 1'b1;
                        end else if (c_q.vwe) begin
                            c_d.act = wsr_merge(c_q.act, wrd, 1'b1);
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // visible status word with busy and latch folded in
        c_d.view          = c_d.act;
        c_d.view[ST_BUSY] = c_d.busy;
        c_d.view[ST_WEL]  = c_d.write_latch;
        if (factory_clr) begin
            c_d.nv = ST_RESET;
        end
        if (rst) begin
            c_d.act  = c_d.nv;
            c_d.pend = c_d.nv;
            c_d.view = c_d.nv;
            c_d.write_latch  = 1'b0;
            c_d.vwe  = 1'b0;
            c_d.busy = 1'b0;
            c_d.cs_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        c_q <= c_d;
    end

    assign status_word = c_q.view;

    // ------------------------------------------------------------ link

    // status word into the serial clock domain
    sfs_sync2 #(
        .W   (16),
        .RST (ST_RESET)
    ) u_stat_sync (
        .clk (flash_sclk),
        .clr (rst),
        .d   (c_q.view),
        .q   (stat_s)
    );

    // marks the first edge of a frame
    always_ff @(posedge flash_sclk or posedge cs_n) begin
        if (cs_n) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // rising-edge command, address, mode and data sampling
    always_comb begin
        sfs_link_t b;
        logic [7:0] cmd;
        logic [7:0] mb;
        b   = l_q;
        cmd = '0;
        mb  = '0;
        if (fresh_q) begin
            b.cnt    = '0;
            b.nbits  = '0;
            b.pos    = '0;
            b.shift  = '0;
            b.dio    = l_q.cont;
            b.phase  = l_q.cont ? PH_ADDR : PH_CMD;
            b.lanes  = l_q.cont ? LN_TWO : LN_ONE;
            b.opcode = l_q.cont ? OP_DIO : 8'h00;
        end
        l_d       = b;
        l_d.nbits = (b.nbits == NBITS_MAX) ? b.nbits : b.nbits + 6'h01;
        l_d.cnt   = b.cnt + 5'h01;
        case (b.phase)
            PH_CMD: begin
                cmd        = {b.opcode[6:0], io_in[0]};
                l_d.opcode = cmd;
                if (b.cnt == CMD_LAST) begin
                    l_d.cnt   = '0;
                    l_d.phase = PH_IDLE;
                    if (cmd == OP_RDSR1 || cmd == OP_RDSR2) begin
                        l_d.phase = PH_STAT;
                    end else if (cmd == OP_WRSR) begin
                        l_d.phase = PH_WSR;
                    end else if (!stat_s[ST_BUSY]) begin
                        if (cmd == OP_READ || cmd == OP_FAST) begin
                            l_d.phase = PH_ADDR;
                        end else if (cmd == OP_DOUT) begin
                            l_d.phase = PH_ADDR;
                            l_d.lanes = LN_TWO;
                        end else if (cmd == OP_QOUT && stat_s[ST_QE]) begin
                            l_d.phase = PH_ADDR;
                            l_d.lanes = LN_FOUR;
                        end else if (cmd == OP_DIO) begin
                            l_d.phase = PH_ADDR;
                            l_d.lanes = LN_TWO;
                            l_d.dio   = 1'b1;
                        end
                    end
                end
            end
            PH_ADDR: begin
                if (b.dio) begin
                    // odd bit on line one, even on line zero
                    l_d.addr = {b.addr[21:0], io_in[1], io_in[0]};
                    if (b.cnt == DADDR_LAST) begin
                        l_d.cnt   = '0;
                        l_d.phase = PH_MODE;
                    end
                end else begin
                    l_d.addr = {b.addr[22:0], io_in[0]};
                    if (b.cnt == ADDR_LAST) begin
                        l_d.cnt   = '0;
                        l_d.phase = (b.opcode == OP_READ) ? PH_DATA
                                                          : PH_DUMMY;
                    end
                end
            end
            PH_MODE: begin
                mb       = {b.mode[5:0], io_in[1], io_in[0]};
                l_d.mode = mb;
                if (b.cnt == MODE_LAST) begin
                    l_d.cnt   = '0;
                    l_d.phase = PH_DATA;
                    l_d.cont  = (mb[5:4] == CONT_KEY);
                end
            end
            PH_DUMMY: begin
                if (b.cnt == DUMMY_LAST) begin
                    l_d.cnt   = '0;
                    l_d.phase = PH_DATA;
                end
            end
            PH_DATA: begin
                l_d.pos = b.pos + 3'h1;
                if (b.pos == byte_last(b.lanes)) begin
                    l_d.pos  = '0;
                    l_d.addr = b.addr + 24'h000001;
                end
            end
            PH_STAT: begin
                l_d.pos = b.pos + 3'h1;
            end
            PH_WSR: begin
                l_d.shift = {b.shift[14:0], io_in[0]};
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge flash_sclk or posedge rst) begin
        if (rst) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // falling-edge pin drive for data and status out
    always_comb begin
        logic [7:0] dbyte;
        logic [7:0] sh;
        logic [2:0] amt;
        p_d   = '0;
        amt   = '0;
        sh    = '0;
        dbyte = c_q.mem[l_q.addr[MEM_AW-1:0]];
        if (l_q.phase == PH_STAT) begin
            dbyte = (l_q.opcode == OP_RDSR2) ? stat_s[15:8] : stat_s[7:0];
        end
        case (l_q.lanes)
            LN_TWO:  amt = {l_q.pos[1:0], 1'b0};
            LN_FOUR: amt = {l_q.pos[0], 2'h0};
            default: amt = l_q.pos;
        endcase
        sh = dbyte << amt;
        if (!fresh_q &&
            (l_q.phase == PH_DATA || l_q.phase == PH_STAT)) begin
            case (l_q.lanes)
                LN_TWO: begin
                    p_d.oe  = 4'h3;
                    p_d.out = {2'h0, sh[7], sh[6]};
                end
                LN_FOUR: begin
                    p_d.oe  = 4'hf;
                    p_d.out = sh[7:4];
                end
                default: begin
                    p_d.oe  = 4'h2;
                    p_d.out = {2'h0, sh[7], 1'b0};
                end
            endcase
        end
    end

    always_ff @(negedge flash_sclk or posedge cs_n) begin
        if (cs_n) begin
            p_q <= '0;
        end else begin
            p_q <= p_d;
        end
    end

    assign io_out = p_q.out;
    assign io_oe  = p_q.oe;
endmodule
`default_nettype wire

// *** sfs_flash_sva.sv ***
// assertion checker for the serial flash status and read logic
`timescale 1ns/1ps
`default_nettype none
module sfs_flash_chk
    import sfs_pkg::*;
#(
    parameter int WSR_CYC = 20
) (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        factory_clr,
    input wire logic        flash_sclk,
    input wire logic        cs_n,
    input wire logic [3:0]  io_out,
    input wire logic [3:0]  io_oe,
    input wire logic [15:0] status_word
);
    logic [31:0] busy_cnt_q;

    // length of the current busy stretch in core cycles
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_cnt_q <= '0;
        end else begin
            busy_cnt_q <= status_word[ST_BUSY] ? busy_cnt_q + 32'h1 : '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_oe_deselect: assert property (cs_n |-> io_oe == 4'h0)
        else $error("data lines driven while deselected");
    a_oe_lanes: assert property (io_oe inside
        {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("illegal output enable pattern");
    a_top_zero: assert property (status_word[15] == 1'b0)
        else $error("read-only status bit 15 set");
    a_latch_end: assert property ($fell(status_word[ST_BUSY])
        |-> !status_word[ST_WEL])
        else $error("write latch still set after busy cycle");
    a_busy_span: assert property ($fell(status_word[ST_BUSY])
        |-> busy_cnt_q >= 32'(WSR_CYC))
        else $error("busy cycle too short");
    a_busy_bound: assert property ($rose(status_word[ST_BUSY])
        |-> ##[1:1000] !status_word[ST_BUSY])
        else $error("busy cycle never ends");
    a_locks_hold: assert property (disable iff (rst || factory_clr)
        ($past(status_word[13:10]) & ~status_word[13:10]) == 4'h0)
        else $error("lock bit cleared");
    a_busy_quiet: assert property (status_word[ST_BUSY]
        |-> (io_oe & 4'hd) == 4'h0)
        else $error("read answered during busy cycle");
    a_out_stable: assert property (flash_sclk && $past(flash_sclk)
        |-> $stable(io_out))
        else $error("data changed while serial clock high");
    a_quad_gate: assert property (io_oe == 4'hf
        |-> status_word[ST_QE])
        else $error("quad output without quad enable");
endmodule
`default_nettype wire

// *** sfs_host.sv ***
// spi host model that frames instructions into the flash logic
`timescale 1ns/1ps
`default_nettype none
module sfs_host (
    output var  logic       cs_n,
    output var  logic       flash_sclk,
    output var  logic [3:0] io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    logic [3:0] last;
    logic [3:0] oe_seen;

    // idle levels after time zero so async clears see cs_n rise
    initial begin
        #1;
        cs_n = 1'b1;
        flash_sclk = 1'b0;
        io_in = 4'h0;
        last = 4'h0;
        oe_seen = 4'h0;
    end

    // one mode 0 clock: drive, rise and sample, fall
    task automatic tick(input logic [3:0] d, output logic [3:0] q);
        io_in = d;
        last = d;
        #16 flash_sclk = 1'b1;
        q = (io_out & io_oe) | (~d & ~io_oe); // released lines read inverse
        oe_seen = oe_seen | io_oe;
        #16 flash_sclk = 1'b0;
    endtask

    // select with a phase unrelated to the core clock
    task automatic open();
        #3.3 cs_n = 1'b0;
        oe_seen = 4'h0;
        #5.1;
    endtask

    // deselect, lines released, gap before the next frame
    task automatic close();
        #7.7 cs_n = 1'b1;
        io_in = ~last;
        #60;
    endtask

    // released lines toggle every clock, no stale value left
    task automatic idle(input int n);
        logic [3:0] q;
        for (int i = 0; i < n; i++) tick(~last, q);
    endtask

    // byte out, msb first; dual puts odd bits on line one
    task automatic put(input logic [7:0] b, input int w);
        logic [3:0] q;
        if (w == 1)
            for (int i = 7; i >= 0; i--) tick({3'h0, b[i]}, q);
        else
            for (int i = 3; i >= 0; i--)
                tick({2'h0, b[2*i+1], b[2*i]}, q);
    endtask

    // byte in over one, two or four lines with inputs released
    task automatic get(input int w, output logic [7:0] b);
        logic [3:0] q;
        b = 8'h00;
        for (int i = 0; i < 8 / w; i++) begin
            tick(~last, q);
            b = w == 1 ? {b[6:0], q[1]} :
                w == 2 ? {b[5:0], q[1:0]} : {b[3:0], q};
        end
    endtask
endmodule
`default_nettype wire

// *** sfs_flash_tb.sv ***
// testbench of the serial flash status and read logic
`timescale 1ns/1ps
`default_nettype none
module sfs_flash_tb
    import sfs_pkg::*;
;
    logic        core_clk, rst, factory_clr, mem_wr_en;
    logic [7:0]  mem_wr_addr, mem_wr_data, mode_v;
    logic        cs_n, flash_sclk;
    logic [3:0]  io_in, io_out, io_oe;
    logic [15:0] status_word;
    int          mismatches, checked;

    sfs_flash #(.WSR_CYC(800)) i_dut (.core_clk(core_clk), .rst(rst),
        .factory_clr(factory_clr), .mem_wr_en(mem_wr_en),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .flash_sclk(flash_sclk), .cs_n(cs_n), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .status_word(status_word));
    sfs_host i_host (.cs_n(cs_n), .flash_sclk(flash_sclk), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe));

    // 250 MHz core clock
    initial core_clk = 1'b0;
    always #2 core_clk = ~core_clk;

    function automatic logic [7:0] pat(input logic [7:0] x);
        return x ^ 8'h5a;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // enable frame, then a status write of 8, 12 or 16 data bits
    task automatic wsr(input logic [7:0] pre, b1, b2, input int nb);
        i_host.open();
        i_host.put(pre, 1);
        i_host.close();
        i_host.open();
        i_host.put(OP_WRSR, 1);
        i_host.put(b1, 1);
        if (nb == 16) i_host.put(b2, 1);
        if (nb == 12) i_host.idle(4);
        i_host.close();
    endtask

    // read frame; op 00 means continuous mode, n 0 means refused
    task automatic rd(input logic [7:0] op, input logic [23:0] a,
                      input int w, input int n);
        logic [7:0] b;
        i_host.open();
        if (op != 8'h00) i_host.put(op, 1);
        if (op == OP_DIO || op == 8'h00) begin
            for (int i = 2; i >= 0; i--) i_host.put(a[8*i+:8], 2);
            i_host.put(mode_v, 2);
        end else begin
            for (int i = 2; i >= 0; i--) i_host.put(a[8*i+:8], 1);
            if (op != OP_READ) i_host.idle(8);
        end
        if (n == 0) i_host.idle(8);
        for (int i = 0; i < n; i++) begin
            i_host.get(w, b);
            chk({8'h00, b}, {8'h00, pat(a[7:0] + 8'(i))});
        end
        i_host.close();
    endtask

    task automatic stat(input logic [7:0] op, input logic [7:0] exp);
        logic [7:0] b;
        i_host.open();
        i_host.put(op, 1);
        i_host.get(1, b);
        i_host.close();
        chk({8'h00, b}, {8'h00, exp});
    endtask

    task automatic wait_idle();
        for (int k = 0; k < 1000 && status_word[ST_BUSY] !== 1'b0; k++)
            @(posedge core_clk) #1;
        chk(status_word & 16'h0001, 16'h0000);
        #40;
    endtask

    // watchdog well beyond the expected run
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end

    initial begin
        rst = 1'b0;
        factory_clr = 1'b1;
        mem_wr_en = 1'b0;
        mem_wr_addr = 8'h00;
        mem_wr_data = 8'h00;
        mode_v = 8'h00;
        mismatches = 0;
        checked = 0;
        #1 rst = 1'b1;
        repeat (10) @(posedge core_clk);
        #1 rst = 1'b0;
        factory_clr = 1'b0;
        for (int i = 0; i < 256; i++) begin
            @(posedge core_clk);
            #1 mem_wr_en = 1'b1;
            mem_wr_addr = 8'(i);
            mem_wr_data = pat(8'(i));
        end
        @(posedge core_clk);
        #1 mem_wr_en = 1'b0;
        repeat (4) @(posedge core_clk);
        chk(status_word, ST_RESET);
        wsr(OP_WRDI, 8'hff, 8'h02, 16);
        chk(status_word, ST_RESET);
        wsr(OP_WREN, 8'hff, 8'h02, 16);
        chk(status_word, 16'h0003);
        rd(OP_READ, 24'h000000, 1, 0);
        chk({12'h000, i_host.oe_seen}, 16'h0000);
        stat(OP_RDSR1, 8'h03);
        wait_idle();
        chk(status_word, 16'h02fc);
        stat(OP_RDSR2, 8'h02);
        $display("test status write done");
        rd(OP_READ, 24'h1234fe, 1, 3);
        rd(OP_FAST, 24'h000010, 1, 2);
        rd(OP_DOUT, 24'h000020, 2, 2);
        rd(OP_QOUT, 24'h000030, 4, 2);
        mode_v = 8'h2f;
        rd(OP_DIO, 24'h000040, 2, 2);
        mode_v = 8'h10;
        rd(8'h00, 24'h0000c5, 2, 1);
        rd(OP_READ, 24'h000060, 1, 1);
        $display("test reads done");
        wsr(OP_WREN, 8'h00, 8'h00, 12);
        chk(status_word & 16'hfffd, 16'h02fc);
        wsr(OP_WREN, 8'h5c, 8'h00, 8);
        wait_idle();
        chk(status_word, 16'h005c);
        rd(OP_QOUT, 24'h000030, 4, 0);
        chk({12'h000, i_host.oe_seen}, 16'h0000);
        $display("test short write done");
        wsr(OP_WREN, 8'h00, 8'h3d, 16);
        wait_idle();
        chk(status_word, 16'h3d00);
        wsr(OP_VWREN, 8'h1c, 8'h00, 16);
        chk(status_word, 16'h3d1c);
        @(posedge core_clk);
        #1 rst = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge core_clk);
        chk(status_word, 16'h3d00);
        wsr(OP_WREN, 8'h00, 8'h00, 16);
        wait_idle();
        chk(status_word & ST_LOCK_MASK, ST_LOCK_MASK);
        $display("test locks done");
        finish_test();
    end
endmodule

bind sfs_flash sfs_flash_chk #(.WSR_CYC(WSR_CYC)) i_chk (.core_clk(core_clk),
    .rst(rst), .factory_clr(factory_clr), .flash_sclk(flash_sclk),
    .cs_n(cs_n), .io_out(io_out), .io_oe(io_oe), .status_word(status_word));
`default_nettype wire
